// ---- verilog/scf_pkg.sv ----
/*
  scf_pkg: shared constants and carrier types for the serial controller
  command and interrupt front end.
  assumes: included first in compile order; nothing is imported.
*/
`default_nettype none
package scf_pkg;
  // indexed register pointer values
  localparam logic [2:0] PTR_CMD = 3'h0;
  localparam logic [2:0] PTR_CFG = 3'h1;
  localparam logic [2:0] PTR_VEC = 3'h2;
  // basic command codes, command register bits 5:3
  localparam logic [2:0] CMD_NOP     = 3'h0;
  localparam logic [2:0] CMD_ABORT   = 3'h1;
  localparam logic [2:0] CMD_EXT_REL = 3'h2;
  localparam logic [2:0] CMD_CH_RST  = 3'h3;
  localparam logic [2:0] CMD_RX_ARM  = 3'h4;
  localparam logic [2:0] CMD_TX_CLR  = 3'h5;
  localparam logic [2:0] CMD_ERR_RST = 3'h6;
  localparam logic [2:0] CMD_RETURN  = 3'h7;
  // checksum reset codes, command register bits 7:6
  localparam logic [1:0] CRC_RX  = 2'h1;
  localparam logic [1:0] CRC_TX  = 2'h2;
  localparam logic [1:0] CRC_EOM = 2'h3;
  // interrupt/wait-ready configuration fields
  localparam int CFG_EXT_IE = 0;
  localparam int CFG_TX_IE  = 1;
  localparam int CFG_SAV    = 2;
  localparam int CFG_RXM_LO = 3;
  localparam int CFG_WR_RX  = 5;
  localparam int CFG_WR_RDY = 6;
  localparam int CFG_WR_EN  = 7;
  localparam logic [1:0] RXM_OFF   = 2'h0;
  localparam logic [1:0] RXM_FIRST = 2'h1;
  localparam logic [1:0] RXM_NOPAR = 2'h3;
  // interrupt cause codes, also vector bits 2:1
  localparam logic [1:0] CAUSE_TX  = 2'h0;
  localparam logic [1:0] CAUSE_EXT = 2'h1;
  localparam logic [1:0] CAUSE_RX  = 2'h2;
  localparam logic [1:0] CAUSE_SP  = 2'h3;
  // status bit positions
  localparam int ST_RX_AVAIL = 0;
  localparam int ST_INT_PEND = 1;
  localparam int ST_TX_EMPTY = 2;
  localparam int ST_EXT_LAT  = 3;
  localparam int SP_PARITY   = 4;
  localparam int SP_OVERRUN  = 5;
  localparam int SP_FRAMING  = 6;
  localparam int SP_EOF      = 7;
  // return-from-interrupt opcode bytes, then register reset values and sync depth
  localparam logic [7:0] RET_BYTE1 = 8'hed;
  localparam logic [7:0] RET_BYTE2 = 8'h4d;
  localparam logic [7:0] RST_CFG   = 8'h00;
  localparam logic [7:0] RST_VEC   = 8'h00;
  localparam int SYNC_STAGES = 2;

  // channel events from the serial engine, same clock
  typedef struct packed {
    logic ext_event;
    logic tx_empty;
    logic rx_char;
    logic parity_err;
    logic overrun_err;
    logic framing_err;
    logic end_of_frame;
    logic rx_full;
  } scf_ev_t;

  // one-cycle command pulses to the serial engine
  typedef struct packed {
    logic abort_tx;
    logic chan_reset;
    logic rx_crc_reset;
    logic tx_crc_reset;
    logic eom_reset;
  } scf_cmd_t;
endpackage
`default_nettype wire

// ---- verilog/scf_chan.sv ----
/*
  scf_chan: per-channel interrupt sources, error latches, configuration
  register and wait/ready pin.
  assumes: events come from logic on clk; command pulses last one cycle.
*/
`default_nettype none
module scf_chan (
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic           chan_rst,
  input  wire logic           cfg_we,
  input  wire logic [7:0]     wdata,
  input  wire logic           ext_rel,
  input  wire logic           rx_arm,
  input  wire logic           tx_clr,
  input  wire logic           err_rst,
  input  wire logic           ack,
  input  wire logic [1:0]     ack_cause,
  input  wire logic           data_sel,
  input  wire logic           data_rd,
  input  wire scf_pkg::scf_ev_t ev,
  output logic [7:0]          cfg_q,
  output logic [3:0]          pend_q,
  output logic                ext_lat_q,
  output logic                par_q,
  output logic                ovr_q,
  output logic                wrdy_o,
  output logic                wrdy_oe
);
  logic       tx_empty_q;
  logic       armed_q;
  logic [1:0] rxm;
  logic       special;
  logic [3:0] set_v;
  logic [3:0] clr_v;

  assign rxm = cfg_q[scf_pkg::CFG_RXM_LO +: 2];
  // mode 11 leaves parity out of the special conditions [R14]
  assign special = ev.overrun_err | ev.framing_err | ev.end_of_frame |
                   (ev.parity_err & (rxm != scf_pkg::RXM_NOPAR));

  // interrupt sources per cause
  always_comb begin
    set_v = 4'h0;
    clr_v = 4'h0;
    set_v[scf_pkg::CAUSE_TX] = cfg_q[scf_pkg::CFG_TX_IE] &
                               ev.tx_empty & ~tx_empty_q; // [R12]
    set_v[scf_pkg::CAUSE_EXT] = cfg_q[scf_pkg::CFG_EXT_IE] &
                                ev.ext_event & ~ext_lat_q; // [R11] [R4]
    set_v[scf_pkg::CAUSE_RX] = ev.rx_char & ((rxm == scf_pkg::RXM_FIRST) ?
                               armed_q : (rxm != scf_pkg::RXM_OFF)); // [R14]
    set_v[scf_pkg::CAUSE_SP] = special & (rxm != scf_pkg::RXM_OFF); // [R14]
    clr_v[scf_pkg::CAUSE_TX] = tx_clr; // [R7]
    if (ack)
      clr_v[ack_cause] = 1'b1;
  end

  // set wins over clear for every pending bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q     <= 4'h0;
      tx_empty_q <= 1'b0;
    end else if (chan_rst) begin
      pend_q     <= 4'h0; // [R24]
      tx_empty_q <= 1'b0;
    end else begin
      pend_q     <= (pend_q & ~clr_v) | set_v;
      tx_empty_q <= ev.tx_empty;
    end
  end

  // latches: external status, first-character arm, error flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_lat_q <= 1'b0;
      armed_q   <= 1'b1;
      par_q     <= 1'b0;
      ovr_q     <= 1'b0;
      cfg_q     <= scf_pkg::RST_CFG;
    end else if (chan_rst) begin
      ext_lat_q <= 1'b0; // [R5]
      armed_q   <= 1'b1;
      par_q     <= 1'b0;
      ovr_q     <= 1'b0;
      cfg_q     <= scf_pkg::RST_CFG;
    end else begin
      ext_lat_q <= set_v[scf_pkg::CAUSE_EXT] | (ext_lat_q & ~ext_rel); // [R4]
      armed_q   <= rx_arm | (armed_q & ~set_v[scf_pkg::CAUSE_RX]); // [R6]
      par_q     <= ev.parity_err | (par_q & ~err_rst); // [R8]
      ovr_q     <= ev.overrun_err | (ovr_q & ~err_rst); // [R8]
      if (cfg_we)
        cfg_q <= wdata;
    end
  end

  // wait/ready pin: ready drives both levels, wait only pulls low
  always_comb begin
    logic rx_side;
    logic busy;
    rx_side = cfg_q[scf_pkg::CFG_WR_RX]; // [R15]
    busy = rx_side ? ~ev.rx_full : ~ev.tx_empty;
    wrdy_o = 1'b1;
    wrdy_oe = 1'b0;
    if (cfg_q[scf_pkg::CFG_WR_RDY]) begin // [R16]
      wrdy_oe = 1'b1;
      wrdy_o = ~(cfg_q[scf_pkg::CFG_WR_EN] & ~busy); // [R17]
    end else if (cfg_q[scf_pkg::CFG_WR_EN] & busy & data_sel &
                 (data_rd == rx_side)) begin
      wrdy_oe = 1'b1;
      wrdy_o = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/scf_front.sv ----
/*
  scf_front: host-facing command interpreter and interrupt daisy-chain
  logic for a two-channel serial controller.
  assumes: bus pins and chain pins are asynchronous to clk and are
  synchronised here; serial engines sit on clk and use the command
  pulses; the board resolves the open-drain interrupt and wait pins.
*/
`default_nettype none
// Operation
// [R1] pointer bits pick next accessed register, then revert to command reg
// [R2] command 000 only updates the pointer
// [R3] command 001 asks the transmitter for an abort sequence, framed mode
// [R4] command 010 releases the latched external status for re-interrupt
// [R5] command 011 resets its channel; on channel A also priority logic
// [R6] command 100 re-arms the first-character receive interrupt
// [R7] command 101 clears pending transmit-empty interrupt
// [R8] command 110 clears latched parity and overrun flags
// [R9] command 111 on channel A acts like a return opcode
// [R10] top command bits reset rx checksum, tx checksum or underrun latch
// [R11] external/status enable raises interrupt on status events
// [R12] transmit enable raises interrupt when buffer becomes empty
// [R13] status-affects-vector on channel B modifies vector bits 3:1
// [R14] receive mode: off, first char, every char, every char sans parity
// [R15] wait/ready bit five picks receive or transmit buffer
// [R16] wait/ready bit six picks ready or wait function
// [R17] bit seven enables pin; ready is low while buffer empty; on the receive side the code drives it low while buffer full
// [R18] request state frozen while fetch indication is active
// [R19] first return byte never acknowledges; priority output restored
// [R20] second return byte ends service, priority output goes high
// [R21] host acknowledges with fetch low first, then io request low
// [R22] host programs format/mode register before other registers
// [R23] modified vector: bit3 channel, bits 2:1 cause code
// [R24] any reset returns pointer to command reg, clears pending
module scf_front (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             chip_enable_n,
  input  wire logic             io_request_n,
  input  wire logic             read_n,
  input  wire logic             chan_b_sel,
  input  wire logic             ctrl_sel,
  input  wire logic             fetch_cycle_n,
  input  wire logic             priority_in,
  input  wire logic [7:0]       data_in,
  output logic [7:0]            data_out,
  output logic                  data_oe,
  output logic                  int_o,
  output logic                  int_oe,
  output logic                  priority_out,
  input  wire scf_pkg::scf_ev_t ev_a,
  input  wire scf_pkg::scf_ev_t ev_b,
  output scf_pkg::scf_cmd_t     cmd_a,
  output scf_pkg::scf_cmd_t     cmd_b,
  output logic                  wrdy_a_o,
  output logic                  wrdy_a_oe,
  output logic                  wrdy_b_o,
  output logic                  wrdy_b_oe
);
  localparam int PW = 15;

  logic [1:0]    rst_sync_q;
  logic          rst_n;
  logic [PW-1:0] pin_s1_q;
  logic [PW-1:0] pin_s2_q;
  logic          ce_s;
  logic          io_request_n_s;
  logic          rd_s;
  logic          chb_s;
  logic          ctl_s;
  logic          fetch_s;
  logic          pri_s;
  logic [7:0]    din_s;
  logic          bus_act;
  logic          ack_act;
  logic          op_act;
  logic          bus_act_q;
  logic          ack_act_q;
  logic          op_act_q;
  logic          wr_stb;
  logic          rd_stb;
  logic          ack_stb;
  logic          op_stb;
  logic [2:0]    ptr_a_q;
  logic [2:0]    ptr_b_q;
  logic [2:0]    ptr_sel;
  logic [7:0]    vec_q;
  logic          ctl_wr;
  logic [2:0]    basic;
  logic [1:0]    crc_code;
  logic          cmd_en;
  logic [1:0]    cfg_we;
  logic [1:0]    ext_rel;
  logic [1:0]    rx_arm;
  logic [1:0]    tx_clr;
  logic [1:0]    err_rst;
  logic [1:0]    ch_rst_q;
  logic          return_from_irq_opcode_cmd;
  logic [7:0]    cfg_a;
  logic [7:0]    cfg_b;
  logic [3:0]    pend_a;
  logic [3:0]    pend_b;
  logic [1:0]    ext_lat;
  logic [1:0]    par_lat;
  logic [1:0]    ovr_lat;
  logic          ip_q;
  logic          ius_q;
  logic          ed_seen_q;
  logic          ack_drv_q;
  logic          win_chan_a;
  logic [1:0]    win_cause;
  logic [7:0]    vec_out;
  logic [1:0]    ack_ch;
  logic [7:0]    rd_mux;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // bus and chain pins cross in with two flops; only stage two is read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= {PW{1'b1}};
      pin_s2_q <= {PW{1'b1}};
    end else begin
      pin_s1_q <= {chip_enable_n, io_request_n, read_n, chan_b_sel,
                   ctrl_sel, fetch_cycle_n, priority_in, data_in};
      pin_s2_q <= pin_s1_q;
    end
  end
  assign {ce_s, io_request_n_s, rd_s, chb_s, ctl_s, fetch_s, pri_s, din_s} =
    pin_s2_q;

  // cycle kinds: register access, acknowledge, opcode fetch [R21]
  assign bus_act = ~ce_s & ~io_request_n_s & fetch_s;
  assign ack_act = ~fetch_s & ~io_request_n_s;
  assign op_act  = ~fetch_s & ~rd_s & io_request_n_s;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_act_q <= 1'b0;
      ack_act_q <= 1'b0;
      op_act_q  <= 1'b0;
    end else begin
      bus_act_q <= bus_act;
      ack_act_q <= ack_act;
      op_act_q  <= op_act;
    end
  end

  // one strobe per host cycle, taken on the leading edge
  assign wr_stb  = bus_act & ~bus_act_q & rd_s;
  assign rd_stb  = bus_act & ~bus_act_q & ~rd_s;
  assign ack_stb = ack_act & ~ack_act_q;
  assign op_stb  = op_act & ~op_act_q;

  assign ptr_sel  = chb_s ? ptr_b_q : ptr_a_q;
  assign ctl_wr   = wr_stb & ctl_s;
  assign basic    = din_s[5:3];
  assign crc_code = din_s[7:6];
  assign cmd_en   = ctl_wr & (ptr_sel == scf_pkg::PTR_CMD);

  // command decode into per-channel strobes [R2]
  always_comb begin
    cfg_we  = 2'h0;
    ext_rel = 2'h0;
    rx_arm  = 2'h0;
    tx_clr  = 2'h0;
    err_rst = 2'h0;
    if (ctl_wr & (ptr_sel == scf_pkg::PTR_CFG))
      cfg_we[chb_s] = 1'b1;
    if (cmd_en) begin
      ext_rel[chb_s] = (basic == scf_pkg::CMD_EXT_REL); // [R4]
      rx_arm[chb_s]  = (basic == scf_pkg::CMD_RX_ARM); // [R6]
      tx_clr[chb_s]  = (basic == scf_pkg::CMD_TX_CLR); // [R7]
      err_rst[chb_s] = (basic == scf_pkg::CMD_ERR_RST); // [R8]
    end
  end
  // the return command is refused on channel B [R9]
  assign return_from_irq_opcode_cmd = cmd_en & ~chb_s & (basic == scf_pkg::CMD_RETURN);

  // pointer: set by a command write other than channel reset, back to zero after any other control-port access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_a_q <= scf_pkg::PTR_CMD; // [R24]
      ptr_b_q <= scf_pkg::PTR_CMD;
    end else if ((wr_stb | rd_stb) & ctl_s) begin
      if (!chb_s)
        ptr_a_q <= (cmd_en && basic != scf_pkg::CMD_CH_RST) ?
                   din_s[2:0] : scf_pkg::PTR_CMD; // [R1] [R24]
      else
        ptr_b_q <= (cmd_en && basic != scf_pkg::CMD_CH_RST) ?
                   din_s[2:0] : scf_pkg::PTR_CMD; // [R1] [R24]
    end
  end

  // vector register lives on channel B only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      vec_q <= scf_pkg::RST_VEC;
    else if (ctl_wr & chb_s & (ptr_sel == scf_pkg::PTR_VEC))
      vec_q <= din_s;
  end

  // registered command pulses out to the serial engines
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_a    <= '0;
      cmd_b    <= '0;
      ch_rst_q <= 2'h0;
    end else begin
      cmd_a <= '0;
      cmd_b <= '0;
      ch_rst_q <= 2'h0;
      if (cmd_en) begin
        if (!chb_s) begin
          cmd_a.abort_tx     <= (basic == scf_pkg::CMD_ABORT); // [R3]
          cmd_a.chan_reset   <= (basic == scf_pkg::CMD_CH_RST); // [R5]
          cmd_a.rx_crc_reset <= (crc_code == scf_pkg::CRC_RX); // [R10]
          cmd_a.tx_crc_reset <= (crc_code == scf_pkg::CRC_TX); // [R10]
          cmd_a.eom_reset    <= (crc_code == scf_pkg::CRC_EOM); // [R10]
          ch_rst_q[0]        <= (basic == scf_pkg::CMD_CH_RST); // [R5]
        end else begin
          cmd_b.abort_tx     <= (basic == scf_pkg::CMD_ABORT); // [R3]
          cmd_b.chan_reset   <= (basic == scf_pkg::CMD_CH_RST); // [R5]
          cmd_b.rx_crc_reset <= (crc_code == scf_pkg::CRC_RX); // [R10]
          cmd_b.tx_crc_reset <= (crc_code == scf_pkg::CRC_TX); // [R10]
          cmd_b.eom_reset    <= (crc_code == scf_pkg::CRC_EOM); // [R10]
          ch_rst_q[1]        <= (basic == scf_pkg::CMD_CH_RST); // [R5]
        end
      end
    end
  end

  // acknowledge clears the winning cause in its own channel
  assign ack_ch = {2{ack_stb & ip_q & pri_s & ~ius_q}} &
                  {~win_chan_a, win_chan_a};

  scf_chan u_chan_a (
    .clk       (clk),
    .rst_n     (rst_n),
    .chan_rst  (ch_rst_q[0]),
    .cfg_we    (cfg_we[0]),
    .wdata     (din_s),
    .ext_rel   (ext_rel[0]),
    .rx_arm    (rx_arm[0]),
    .tx_clr    (tx_clr[0]),
    .err_rst   (err_rst[0]),
    .ack       (ack_ch[0]),
    .ack_cause (win_cause),
    .data_sel  (bus_act & ~ctl_s & ~chb_s),
    .data_rd   (~rd_s),
    .ev        (ev_a),
    .cfg_q     (cfg_a),
    .pend_q    (pend_a),
    .ext_lat_q (ext_lat[0]),
    .par_q     (par_lat[0]),
    .ovr_q     (ovr_lat[0]),
    .wrdy_o    (wrdy_a_o),
    .wrdy_oe   (wrdy_a_oe)
  );

  scf_chan u_chan_b (
    .clk       (clk),
    .rst_n     (rst_n),
    .chan_rst  (ch_rst_q[1]),
    .cfg_we    (cfg_we[1]),
    .wdata     (din_s),
    .ext_rel   (ext_rel[1]),
    .rx_arm    (rx_arm[1]),
    .tx_clr    (tx_clr[1]),
    .err_rst   (err_rst[1]),
    .ack       (ack_ch[1]),
    .ack_cause (win_cause),
    .data_sel  (bus_act & ~ctl_s & chb_s),
    .data_rd   (~rd_s),
    .ev        (ev_b),
    .cfg_q     (cfg_b),
    .pend_q    (pend_b),
    .ext_lat_q (ext_lat[1]),
    .par_q     (par_lat[1]),
    .ovr_q     (ovr_lat[1]),
    .wrdy_o    (wrdy_b_o),
    .wrdy_oe   (wrdy_b_oe)
  );

  // channel A outranks B; receive special, receive, transmit, external
  always_comb begin
    logic [3:0] p;
    p = (|pend_a) ? pend_a : pend_b;
    win_chan_a = |pend_a;
    if (p[scf_pkg::CAUSE_SP])
      win_cause = scf_pkg::CAUSE_SP;
    else if (p[scf_pkg::CAUSE_RX])
      win_cause = scf_pkg::CAUSE_RX;
    else if (p[scf_pkg::CAUSE_TX])
      win_cause = scf_pkg::CAUSE_TX;
    else
      win_cause = scf_pkg::CAUSE_EXT;
  end

  // status-affects-vector bit is taken from channel B only [R13] [R23]
  assign vec_out = cfg_b[scf_pkg::CFG_SAV] ?
                   {vec_q[7:4], win_chan_a, win_cause, vec_q[0]} : vec_q;

  // request state only moves outside fetch cycles [R18]
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      ip_q <= 1'b0;
    else if (ch_rst_q[0])
      ip_q <= 1'b0; // [R5]
    else if (fetch_s)
      ip_q <= (|pend_a) | (|pend_b); // [R18]
  end

  // service state and return-opcode tracking
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ius_q     <= 1'b0;
      ed_seen_q <= 1'b0;
    end else if (ch_rst_q[0]) begin
      ius_q     <= 1'b0; // [R5]
      ed_seen_q <= 1'b0;
    end else begin
      if (ack_stb & ip_q & pri_s & ~ius_q)
        ius_q <= 1'b1;
      else if (return_from_irq_opcode_cmd & pri_s)
        ius_q <= 1'b0; // [R9]
      else if (op_stb & ed_seen_q & (din_s == scf_pkg::RET_BYTE2) & pri_s)
        ius_q <= 1'b0; // [R20]
      // first byte arms the second; any other fetch disarms [R19]
      if (op_stb)
        ed_seen_q <= (din_s == scf_pkg::RET_BYTE1);
    end
  end

  // status read mux by pointer
  always_comb begin
    rd_mux = 8'h00;
    case (ptr_sel)
      scf_pkg::PTR_CMD: begin
        rd_mux[scf_pkg::ST_RX_AVAIL] = chb_s ? ev_b.rx_full : ev_a.rx_full;
        rd_mux[scf_pkg::ST_INT_PEND] = ~chb_s & ip_q;
        rd_mux[scf_pkg::ST_TX_EMPTY] = chb_s ? ev_b.tx_empty : ev_a.tx_empty;
        rd_mux[scf_pkg::ST_EXT_LAT]  = ext_lat[chb_s];
      end
      scf_pkg::PTR_CFG: begin
        rd_mux[scf_pkg::SP_PARITY]  = par_lat[chb_s];
        rd_mux[scf_pkg::SP_OVERRUN] = ovr_lat[chb_s];
        rd_mux[scf_pkg::SP_FRAMING] = chb_s ? ev_b.framing_err :
                                      ev_a.framing_err;
        rd_mux[scf_pkg::SP_EOF]     = chb_s ? ev_b.end_of_frame :
                                      ev_a.end_of_frame;
      end
      scf_pkg::PTR_VEC: rd_mux = chb_s ? vec_out : 8'h00; // [R13]
      default: rd_mux = 8'h00;
    endcase
  end

  // data bus: registered byte, driven for control reads and our ack
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out  <= 8'h00;
      ack_drv_q <= 1'b0;
      data_oe   <= 1'b0;
    end else begin
      if (rd_stb & ctl_s)
        data_out <= rd_mux;
      else if (ack_stb & ip_q & pri_s & ~ius_q)
        data_out <= vec_out; // [R23]
      if (ack_stb)
        ack_drv_q <= ip_q & pri_s & ~ius_q;
      else if (!ack_act)
        ack_drv_q <= 1'b0;
      data_oe <= (bus_act & ~rd_s & ctl_s & ~rd_stb) |
                 (ack_act & ack_drv_q);
    end
  end

  // open-drain interrupt request, held while waiting for service
  assign int_o  = 1'b0;
  assign int_oe = ip_q & ~ius_q;

  // a request lowers the chain only until the first return byte [R19]
  assign priority_out = pri_s & ~ius_q & ~(ip_q & ~ed_seen_q); // [R20]
endmodule
`default_nettype wire

// ---- tb/scf_front_props.sv ----
/* scf_front_props: pin-level checks on scf_front.
   assumes: bound to every scf_front by the line below the module. */
`default_nettype none
module scf_front_props (
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic              io_request_n,
  input wire logic              read_n,
  input wire logic              fetch_cycle_n,
  input wire logic              priority_in,
  input wire logic              data_oe,
  input wire logic              int_oe,
  input wire logic              priority_out,
  input wire scf_pkg::scf_cmd_t cmd_a
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // the checksum field names one reset at most
  property p_crc; $onehot0({cmd_a.rx_crc_reset, cmd_a.tx_crc_reset,
    cmd_a.eom_reset}); endproperty
  a_crc: assert property (p_crc)
    else $error("checksum resets overlap");
  // abort only follows a host write; channel reset follows a request and lasts one cycle
  property p_abort; cmd_a.abort_tx |-> !$past(io_request_n, 3)
    && $past(read_n, 3); endproperty
  a_abort: assert property (p_abort)
    else $error("abort without write");
  property p_chrst; cmd_a.chan_reset |-> !$past(io_request_n, 3)
    ##1 !cmd_a.chan_reset; endproperty
  a_chrst: assert property (p_chrst)
    else $error("channel reset pulse wrong");
  // nothing driven as reset ends
  property p_rst; $rose(nrst) |-> !data_oe && !int_oe && priority_out;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs active after reset");
  // bus driven only in answer to a strobe, and let go after it
  property p_oe_on; $rose(data_oe) |-> !$past(io_request_n, 2); endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("bus driven without strobe");
  property p_oe_off; io_request_n [*4] |-> !data_oe; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("bus held after strobe");
  property p_chain; !priority_in [*3] |-> !priority_out; endproperty
  a_chain: assert property (p_chain)
    else $error("chain passed while blocked");
  // a new request may not appear inside a fetch
  property p_frz; $rose(int_oe) |-> $past(fetch_cycle_n, 2); endproperty
  a_frz: assert property (p_frz)
    else $error("request changed in fetch");
endmodule
bind scf_front scf_front_props scf_front_props_inst (.clk, .nrst,
  .io_request_n, .read_n, .fetch_cycle_n, .priority_in, .data_oe,
  .int_oe, .priority_out, .cmd_a);
`default_nettype wire

// ---- tb/scf_host.sv ----
/* scf_host: host processor model on the front end's parallel bus.
   assumes: its tasks are entered at a falling edge of clk. */
`default_nettype none
module scf_host (
  input  wire logic       clk,
  input  wire logic [7:0] data_out,
  output logic            chip_enable_n,
  output logic            io_request_n,
  output logic            read_n,
  output logic            chan_b_sel,
  output logic            ctrl_sel,
  output logic            fetch_cycle_n,
  output logic [7:0]      host_d
);
  // bus parked; released data lines show the inverted byte
  task automatic idle();
    {chip_enable_n, io_request_n, read_n, fetch_cycle_n} = 4'hf;
    host_d = ~host_d;
    repeat (4) @(negedge clk);
  endtask
  initial begin
    {chan_b_sel, ctrl_sel, host_d} = 10'h000;
    idle();
  end
  // one cycle held four clocks, so a slow sync still sees it
  task automatic cyc(input logic b, c, rd, fe, io, input logic [7:0] d,
                     output logic [7:0] q);
    {chan_b_sel, ctrl_sel, read_n, fetch_cycle_n, host_d} = {b, c, rd, fe, d};
    if (!fe) repeat (2) @(negedge clk);
    io_request_n = !io;
    chip_enable_n = !(io && fe);
    repeat (4) @(negedge clk);
    q = data_out;
    idle();
  endtask
endmodule
`default_nettype wire

// ---- tb/scf_front_tb_top.sv ----
/* scf_front_tb_top: self-checking bench for the command front end.
   assumes: package, design, host model and checker compiled first. */
`default_nettype none
module scf_front_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk = 1'b0;
  logic              nrst, priority_in, data_oe, int_oe, priority_out;
  logic              chip_enable_n, io_request_n, read_n, chan_b_sel;
  logic              ctrl_sel, fetch_cycle_n, wrdy_a_o, wrdy_a_oe, int_o;
  logic [7:0]        host_d, data_out;
  wire logic [7:0]   data_in;
  scf_pkg::scf_ev_t  ev_a, ev_b;
  scf_pkg::scf_cmd_t cmd_a, cmd_b, seen_a, seen_b;
  int                fails = 0;
  int                check_count = 0;
  always #50 clk = ~clk;
  // device wins the data bus while it drives
  assign data_in = data_oe ? data_out : host_d;
  // sticky record of command pulses
  always @(posedge clk) begin
    seen_a <= seen_a | cmd_a;
    seen_b <= seen_b | cmd_b;
  end
  scf_front scf_front_inst (.clk, .nrst, .chip_enable_n, .io_request_n,
    .read_n, .chan_b_sel, .ctrl_sel, .fetch_cycle_n, .priority_in, .data_in,
    .data_out, .data_oe, .int_o, .int_oe, .priority_out, .ev_a, .ev_b,
    .cmd_a, .cmd_b, .wrdy_a_o, .wrdy_a_oe, .wrdy_b_o(), .wrdy_b_oe());
  scf_host scf_host_inst (.clk, .data_out, .chip_enable_n, .io_request_n,
    .read_n, .chan_b_sel, .ctrl_sel, .fetch_cycle_n, .host_d);
  task automatic chk(input logic [7:0] got, exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic b, input logic [7:0] d);
    logic [7:0] q;
    scf_host_inst.cyc(b, 1'b1, 1'b1, 1'b1, 1'b1, d, q);
  endtask
  task automatic pulse();
    ev_a.ext_event = 1'b1;
    @(negedge clk);
    ev_a.ext_event = 1'b0;
  endtask
  // bounded wait for the request, then judge it
  task automatic int_is(input logic e);
    for (int k = 0; k < 8 && int_oe !== 1'b1; k++) @(negedge clk);
    chk(8'(int_oe), 8'(e));
  endtask
  function automatic scf_pkg::scf_cmd_t exp_cmd(input logic [7:0] d);
    exp_cmd = '{d[5:3] == scf_pkg::CMD_ABORT, d[5:3] == scf_pkg::CMD_CH_RST,
      d[7:6] == scf_pkg::CRC_RX, d[7:6] == scf_pkg::CRC_TX,
      d[7:6] == scf_pkg::CRC_EOM};
  endfunction
  task automatic end_sim();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog far past the run length
  initial begin
    #500000;
    fails++;
    end_sim();
  end
  initial begin
    logic [7:0] q, v, d;
    void'($urandom(32'hce10));
    {nrst, ev_a, ev_b} = '0;
    priority_in = 1'b1;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    chk(8'({int_o, int_oe, priority_out}), 8'h01);
    // ready on transmit, then receive buffer; the 00 must hit command reg
    for (int k = 0; k < 2; k++) begin
      wr(1'b0, {5'h00, scf_pkg::PTR_CFG});
      wr(1'b0, k ? 8'he0 : 8'hc0);
      wr(1'b0, 8'h00);
      repeat (4) begin
        ev_a.tx_empty = 1'($urandom);
        ev_a.rx_full = 1'($urandom);
        @(negedge clk);
        d = 8'({1'b1, k ? !ev_a.rx_full : !ev_a.tx_empty});
        chk(8'({wrdy_a_oe, wrdy_a_o}), d);
      end
    end
    // every command code, random checksum field
    for (int i = 0; i < 8; i++) begin
      d = {2'($urandom), 3'(i), 3'h0};
      priority_in = (i != 4);
      seen_a = '0;
      seen_b = '0;
      wr(1'b0, d);
      chk(8'(seen_a), 8'(exp_cmd(d)));
      chk(8'(seen_b), 8'h00);
      if (i == 3) chk(8'(wrdy_a_oe), 8'h00);
    end
    v = 8'($urandom);
    wr(1'b1, {5'h00, scf_pkg::PTR_VEC});
    wr(1'b1, v);
    wr(1'b1, {5'h00, scf_pkg::PTR_CFG});
    wr(1'b1, 8'h06);
    ev_b.tx_empty = 1'b1;
    int_is(1'b1);
    scf_host_inst.cyc(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'h00, q);
    chk(q, {v[7:4], 1'b0, scf_pkg::CAUSE_TX, v[0]});
    chk(8'(priority_out), 8'h00);
    scf_host_inst.cyc(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, scf_pkg::RET_BYTE1, q);
    chk(8'(priority_out), 8'h00);
    scf_host_inst.cyc(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, scf_pkg::RET_BYTE2, q);
    chk(8'(priority_out), 8'h01);
    ev_b.tx_empty = 1'b0;
    @(negedge clk);
    ev_b.tx_empty = 1'b1;
    wr(1'b1, {2'h0, scf_pkg::CMD_TX_CLR, 3'h0});
    chk(8'(int_oe), 8'h00);
    // external status on A, ended by the return command
    wr(1'b0, {5'h00, scf_pkg::PTR_CFG});
    wr(1'b0, 8'h01);
    pulse();
    int_is(1'b1);
    scf_host_inst.cyc(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'h00, q);
    chk(q, {v[7:4], 1'b1, scf_pkg::CAUSE_EXT, v[0]});
    wr(1'b0, {2'h0, scf_pkg::CMD_RETURN, 3'h0});
    chk(8'(priority_out), 8'h01);
    pulse();
    repeat (4) @(negedge clk);
    chk(8'(int_oe), 8'h00);
    wr(1'b0, {2'h0, scf_pkg::CMD_EXT_REL, 3'h0});
    pulse();
    int_is(1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
